// ==== logic/temp_sensor_pkg.sv ====
// Shared constants and carrier types for the temperature sensor register bank
package temp_sensor_pkg;

  // ----------------------------------------------------------------
  // Register pointer values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TEMPERATURE = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_LOWER = 8'h02;
  localparam logic [7:0] ADDR_UPPER = 8'h03;
  localparam logic [7:0] ADDR_DIE_ID = 8'h0f;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_TEMPERATURE = 16'h0000;
  localparam logic [15:0] RESET_CONFIG = 16'h00ff;
  localparam logic [15:0] RESET_LOWER = 16'h4b00;
  localparam logic [15:0] RESET_UPPER = 16'h5000;
  localparam logic [7:0] RESET_POINTER = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TEMP_LSB = 4;
  localparam int CFG_TRIGGER_BIT = 15;
  localparam int CFG_RATE_LSB = 13;
  localparam int CFG_FAULT_LSB = 11;
  localparam int CFG_POLARITY_BIT = 10;
  localparam int CFG_MODE_BIT = 9;
  localparam int CFG_SHUTDOWN_BIT = 8;

  // ----------------------------------------------------------------
  // Timing: base conversion period at the 250 MHz clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned CONV_BASE_US = 27500;
  localparam int unsigned CONV_BASE_CYCLES = (CONV_BASE_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int PERIOD_W = 27;

  // ----------------------------------------------------------------
  // Byte-level transaction carriers from and to the serial front end
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic wr_valid;
    logic [7:0] wr_data;
    logic rd_req;
    logic stop;
  } host_req_t;

  typedef struct packed {
    logic rd_valid;
    logic [7:0] rd_data;
  } host_rsp_t;

  typedef enum {
    ST_LAUNCH,
    ST_CONVERT,
    ST_STANDBY,
    ST_SLEEP
  } conv_state_t;

endpackage : temp_sensor_pkg

// ==== logic/alert_engine.sv ====
// Fault queue, comparator and interrupt alert logic
`timescale 1ns/1ps
module alert_engine (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic clear_evt,
  input wire logic sample,
  input wire logic [11:0] temp,
  input wire logic [11:0] lower,
  input wire logic [11:0] upper,
  input wire logic [1:0] fault_need,
  input wire logic int_mode,
  input wire logic polarity,
  output logic alert_pin,
  output logic alert_active
);

  logic active_q;
  logic phase_q;
  logic [1:0] count_q;
  logic below;
  logic at_or_above;
  logic fault;
  logic hit;

  // ----------------------------------------------------------------
  // Fault qualification
  // ----------------------------------------------------------------
  // Signed compares; limits at the rails effectively disable the pin
  assign below = $signed(temp) < $signed(lower);
  assign at_or_above = $signed(temp) >= $signed(upper);
  // Interrupt mode follows the phase, comparator mode the alert state
  assign fault = (int_mode ? phase_q : active_q) ? below : at_or_above;
  assign hit = fault && (count_q == fault_need);

  // Fault counter; frozen while an interrupt waits to be cleared
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      count_q <= 2'h0;
    else if (ce)
    begin
      if (flush)
        count_q <= 2'h0;
      else if (clear_evt && int_mode && active_q)
        count_q <= 2'h0;
      else if (sample && !(int_mode && active_q))
        count_q <= (fault && !hit) ? count_q + 2'h1 : 2'h0;
    end
  end

  // Alert state and interrupt phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      active_q <= 1'b0;
      phase_q <= 1'b0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        active_q <= 1'b0;
        phase_q <= 1'b0;
      end
      else if (clear_evt && int_mode && active_q)
      begin
        active_q <= 1'b0;
        phase_q <= ~phase_q;
      end
      else if (sample && hit && !(int_mode && active_q))
        active_q <= int_mode ? 1'b1 : ~active_q;
    end
  end

  // Pin level from a flop, so polarity changes never glitch
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      alert_pin <= 1'b1;
    else if (ce)
      alert_pin <= polarity ? active_q : ~active_q;
  end

  assign alert_active = active_q;

endmodule : alert_engine

// ==== logic/temp_sensor_register_bank.sv ====
// Register bank and conversion sequencer of the temperature sensor
//
// Overview of operation
// - Temperature register is read-only, holding the latest completed 12-bit conversion.
// - Temperature code sits in bits 15:4; bits 3:0 read zero.
// - After reset the temperature reads 0000h until a conversion finishes.
// - Configuration resets to 00FFh; low byte unused, writable, resets to ones.
// - Register bytes move high byte first in both directions.
// - Configuration bit 15 written one starts one conversion; it reads zero.
// - Bits 14:13 pick period 27.5, 55, 110 or 220 ms.
// - Bits 12:11 pick one to four consecutive faults before alerting.
// - Bit 10 sets alert polarity; zero active low, one active high.
// - Bit 9 selects comparator (zero) or interrupt (one) alert behaviour.
// - Bit 8 one selects shutdown, zero continuous conversion.
// - Single-byte write loads bits 15:8 and keeps the low byte.
// - Single-byte read of configuration returns bits 15:8.
// - Lower limit is writable 12-bit code in bits 15:4, reset 4B00h.
// - Upper limit is writable 12-bit code in bits 15:4, reset 5000h.
// - Temperature register exposes only the twelve result bits, read only.
// - Comparator alert sets at or above upper, clears below lower, after count.
// - Interrupt alert clears on read, alert response or shutdown; limits alternate.
// - One-shot works only in shutdown, converts once, then back to shutdown.
// - Any write of the mode bit drops alert, counter and interrupt history.
`timescale 1ns/1ps
module temp_sensor_register_bank #(
  parameter logic [15:0] DIE_ID_CODE = 16'ha5c3, // Arbitrary identifier value
  parameter int unsigned CONV_BASE_CYCLES = temp_sensor_pkg::CONV_BASE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire temp_sensor_pkg::host_req_t host_req,
  output temp_sensor_pkg::host_rsp_t host_rsp,
  input wire logic gc_reset,
  input wire logic alert_resp,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  output logic alert_pin,
  output logic alert_active
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] pointer_q;
  logic [1:0] wr_idx_q;
  logic [7:0] msb_q;
  logic rd_idx_q;
  logic [11:0] temp_q;
  logic [14:0] config_q;
  logic [11:0] lower_q;
  logic [11:0] upper_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic oneshot_q;
  logic [temp_sensor_pkg::PERIOD_W-1:0] period_cnt_q;
  temp_sensor_pkg::conv_state_t state_q;
  temp_sensor_pkg::conv_state_t state_d;

  logic [15:0] config_word;
  logic [15:0] rd_word;
  logic word_wr;
  logic byte_wr;
  logic wr_en;
  logic [15:0] wr_word;
  logic cfg_wr;
  logic trigger;
  logic shutdown;
  logic [1:0] rate;
  logic [temp_sensor_pkg::PERIOD_W-1:0] period_len;
  logic period_done;
  logic sample;

  // ----------------------------------------------------------------
  // Register read view
  // ----------------------------------------------------------------
  // Trigger bit is never stored, so it always reads back as zero
  assign config_word = {1'b0, config_q};
  assign shutdown = config_q[temp_sensor_pkg::CFG_SHUTDOWN_BIT];
  assign rate = config_q[temp_sensor_pkg::CFG_RATE_LSB +: 2];

  // Word selected by the pointer; undefined pointers read zero
  always_comb
  begin
    rd_word = 16'h0000;
    unique case (pointer_q)
      temp_sensor_pkg::ADDR_TEMPERATURE: rd_word = {temp_q, 4'h0};
      temp_sensor_pkg::ADDR_CONFIG: rd_word = config_word;
      temp_sensor_pkg::ADDR_LOWER: rd_word = {lower_q, 4'h0};
      temp_sensor_pkg::ADDR_UPPER: rd_word = {upper_q, 4'h0};
      temp_sensor_pkg::ADDR_DIE_ID: rd_word = DIE_ID_CODE;
      default: rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Write byte sequencing
  // ----------------------------------------------------------------
  // Full word commits on the second data byte, high byte first
  assign word_wr = host_req.wr_valid && (wr_idx_q == 2'h2);
  // A lone data byte commits when the transaction ends
  assign byte_wr = (host_req.start || host_req.stop) && (wr_idx_q == 2'h2);
  assign wr_en = word_wr || byte_wr;
  // Single byte keeps the current low byte of the target
  assign wr_word = word_wr ? {msb_q, host_req.wr_data} : {msb_q, rd_word[7:0]};
  assign cfg_wr = wr_en && (pointer_q == temp_sensor_pkg::ADDR_CONFIG);
  // One-shot honoured only when the written word keeps shutdown
  assign trigger = cfg_wr && wr_word[temp_sensor_pkg::CFG_TRIGGER_BIT]
    && wr_word[temp_sensor_pkg::CFG_SHUTDOWN_BIT];

  // Byte position within the current write transaction
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wr_idx_q <= 2'h0;
    else if (ce)
    begin
      if (host_req.start || host_req.stop || gc_reset)
        wr_idx_q <= 2'h0;
      else if (host_req.wr_valid && wr_idx_q != 2'h3)
        wr_idx_q <= wr_idx_q + 2'h1;
    end
  end

  // First byte of a write sets the pointer; it persists across reads
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pointer_q <= temp_sensor_pkg::RESET_POINTER;
    else if (ce)
    begin
      if (gc_reset)
        pointer_q <= temp_sensor_pkg::RESET_POINTER;
      else if (host_req.wr_valid && wr_idx_q == 2'h0)
        pointer_q <= host_req.wr_data;
    end
  end

  // High data byte held until the word or the transaction completes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      msb_q <= 8'h00;
    else if (ce && host_req.wr_valid && wr_idx_q == 2'h1)
      msb_q <= host_req.wr_data;
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Configuration; the trigger bit is a strobe, never held
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      config_q <= temp_sensor_pkg::RESET_CONFIG[14:0];
    else if (ce)
    begin
      if (gc_reset)
        config_q <= temp_sensor_pkg::RESET_CONFIG[14:0];
      else if (cfg_wr)
        config_q <= wr_word[14:0];
    end
  end

  // Alert limits keep only their twelve code bits
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lower_q <= temp_sensor_pkg::RESET_LOWER[15:4];
      upper_q <= temp_sensor_pkg::RESET_UPPER[15:4];
    end
    else if (ce)
    begin
      if (gc_reset)
      begin
        lower_q <= temp_sensor_pkg::RESET_LOWER[15:4];
        upper_q <= temp_sensor_pkg::RESET_UPPER[15:4];
      end
      else if (wr_en && pointer_q == temp_sensor_pkg::ADDR_LOWER)
        lower_q <= wr_word[15:temp_sensor_pkg::TEMP_LSB];
      else if (wr_en && pointer_q == temp_sensor_pkg::ADDR_UPPER)
        upper_q <= wr_word[15:temp_sensor_pkg::TEMP_LSB];
    end
  end

  // Result register: loaded by the converter or a general-call reset, never by host writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      temp_q <= temp_sensor_pkg::RESET_TEMPERATURE[15:4];
    else if (ce)
    begin
      if (gc_reset)
        temp_q <= temp_sensor_pkg::RESET_TEMPERATURE[15:4];
      else if (sample)
        temp_q <= conv_result;
    end
  end

  // ----------------------------------------------------------------
  // Read byte sequencing
  // ----------------------------------------------------------------
  // Byte index restarts each transaction, so a short read just stops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_idx_q <= 1'b0;
    else if (ce)
    begin
      if (host_req.start || gc_reset)
        rd_idx_q <= 1'b0;
      else if (host_req.rd_req)
        rd_idx_q <= ~rd_idx_q;
    end
  end

  // Read data registered; high byte first, then low, alternating
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid_q <= host_req.rd_req;
      if (host_req.rd_req)
        rd_data_q <= rd_idx_q ? rd_word[7:0] : rd_word[15:8];
    end
  end

  // One driver for the whole response carrier
  assign host_rsp = '{rd_valid: rd_valid_q, rd_data: rd_data_q};

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  // Period doubles per rate code; measured from launch to launch
  assign period_len = temp_sensor_pkg::PERIOD_W'(CONV_BASE_CYCLES) << rate;
  assign period_done = period_cnt_q >= period_len - temp_sensor_pkg::PERIOD_W'(1);
  assign sample = (state_q == temp_sensor_pkg::ST_CONVERT) && conv_done;
  assign conv_start = (state_q == temp_sensor_pkg::ST_LAUNCH);

  // Next state; shutdown is checked only between conversions
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      temp_sensor_pkg::ST_LAUNCH:
        state_d = temp_sensor_pkg::ST_CONVERT;
      temp_sensor_pkg::ST_CONVERT:
        if (conv_done)
          state_d = (oneshot_q || shutdown) ? temp_sensor_pkg::ST_SLEEP
            : temp_sensor_pkg::ST_STANDBY;
      temp_sensor_pkg::ST_STANDBY:
        if (shutdown)
          state_d = temp_sensor_pkg::ST_SLEEP;
        else if (period_done)
          state_d = temp_sensor_pkg::ST_LAUNCH;
      temp_sensor_pkg::ST_SLEEP:
        if (trigger || !shutdown)
          state_d = temp_sensor_pkg::ST_LAUNCH;
    endcase
  end

  // State register; a general-call reset restarts continuous mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= temp_sensor_pkg::ST_LAUNCH;
    else if (ce)
      state_q <= gc_reset ? temp_sensor_pkg::ST_LAUNCH : state_d;
  end

  // One-shot marker, so the sequencer returns to shutdown afterwards
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      oneshot_q <= 1'b0;
    else if (ce)
    begin
      if (gc_reset)
        oneshot_q <= 1'b0;
      else if (state_q == temp_sensor_pkg::ST_SLEEP && trigger)
        oneshot_q <= 1'b1;
      else if (sample)
        oneshot_q <= 1'b0;
    end
  end

  // Period counter; saturates so a long shutdown cannot wrap it
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      period_cnt_q <= '0;
    else if (ce)
    begin
      if (state_q == temp_sensor_pkg::ST_LAUNCH || gc_reset)
        period_cnt_q <= temp_sensor_pkg::PERIOD_W'(1);
      else if (!(&period_cnt_q))
        period_cnt_q <= period_cnt_q + temp_sensor_pkg::PERIOD_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Alert logic
  // ----------------------------------------------------------------
  // Every configuration write rewrites the mode bit, hence flushes
  alert_engine u_alert (
    .clk (clk),
    .arst_n (arst_n),
    .ce (ce),
    .flush (cfg_wr || gc_reset),
    .clear_evt (host_req.rd_req || alert_resp),
    .sample (sample),
    .temp (conv_result),
    .lower (lower_q),
    .upper (upper_q),
    .fault_need (config_q[temp_sensor_pkg::CFG_FAULT_LSB +: 2]),
    .int_mode (config_q[temp_sensor_pkg::CFG_MODE_BIT]),
    .polarity (config_q[temp_sensor_pkg::CFG_POLARITY_BIT]),
    .alert_pin (alert_pin),
    .alert_active (alert_active)
  );

endmodule : temp_sensor_register_bank

// ==== tb/reg_bank_assertions.sv ====
// Port-level checks for the temperature sensor register bank
`timescale 1ns/1ps
module reg_bank_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire temp_sensor_pkg::host_req_t host_req,
  input wire temp_sensor_pkg::host_rsp_t host_rsp,
  input wire logic gc_reset,
  input wire logic alert_resp,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic alert_active
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic busy_q;
  logic any_ev;
  // Any event that may legally drop the alert
  assign any_ev = conv_done | host_req.rd_req | host_req.wr_valid | host_req.stop | host_req.start
                  | alert_resp | gc_reset;
  // Conversion outstanding, so an early relaunch is caught
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      busy_q <= 1'b0;
    else if (conv_start)
      busy_q <= 1'b1;
    else if (conv_done || gc_reset)
      busy_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  rd_answer_a: assert property (ce && host_req.rd_req |=> host_rsp.rd_valid)
    else $error("read byte not answered");
  rd_cause_a: assert property (host_rsp.rd_valid |-> $past(host_req.rd_req))
    else $error("read byte without request");
  rd_hold_a: assert property (!host_req.rd_req && !gc_reset && !$past(gc_reset) |=> $stable(host_rsp.rd_data))
    else $error("read byte changed without request");
  launch_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("launch longer than one cycle");
  launch_idle_a: assert property (conv_start |-> !busy_q)
    else $error("launch while converting");
  gc_restart_a: assert property (gc_reset |=> conv_start && !alert_active ##1 !conv_start)
    else $error("general call did not restart");
  alert_set_a: assert property ($rose(alert_active) |-> $past(conv_done))
    else $error("alert set without a sample");
  alert_drop_a: assert property ($fell(alert_active) |-> $past(any_ev) || $past(any_ev, 2))
    else $error("alert dropped without cause");
  cover property ($rose(alert_active));
  cover property ($fell(alert_active));
  cover property (gc_reset);
  cover property (host_rsp.rd_valid);
endmodule : reg_bank_checker

bind temp_sensor_register_bank reg_bank_checker u_reg_bank_checker (.clk(clk), .arst_n(arst_n), .ce(ce),
  .host_req(host_req), .host_rsp(host_rsp), .gc_reset(gc_reset), .alert_resp(alert_resp),
  .conv_start(conv_start), .conv_done(conv_done), .alert_active(alert_active));

// ==== tb/host_model.sv ====
// Behavioural serial front end standing for the bus host
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire temp_sensor_pkg::host_rsp_t host_rsp,
  output temp_sensor_pkg::host_req_t host_req,
  output logic gc_reset,
  output logic alert_resp
);
  initial
  begin
    host_req = '0;
    gc_reset = 1'b0;
    alert_resp = 1'b0;
  end

  // One strobe set per cycle, changed just after an edge
  task automatic st(input logic s, input logic w, input logic [7:0] d, input logic r, input logic p);
    host_req = '{start: s, wr_valid: w, wr_data: d, rd_req: r, stop: p};
    @(posedge clk);
    #1;
  endtask : st

  // Pointer then up to two data bytes, high byte first
  task automatic wr(input logic [7:0] p, input logic [15:0] v, input int n);
    st(1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
    st(1'b0, 1'b1, p, 1'b0, 1'b0);
    for (int i = 0; i < n; i++)
      st(1'b0, 1'b1, (i == 0) ? v[15:8] : v[7:0], 1'b0, 1'b0);
    st(1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
    st(1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
  endtask : wr

  // Set pointer, then read n bytes; one byte stops after the high byte
  task automatic rd(input logic [7:0] p, input int n, output logic [15:0] v);
    wr(p, 16'h0000, 0);
    st(1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
    v = '0;
    for (int i = 0; i < n; i++)
    begin
      st(1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
      v = {v[7:0], (host_rsp.rd_valid === 1'b1) ? host_rsp.rd_data : 8'hxx};
    end
    st(1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
    st(1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
  endtask : rd

  // General call reset or alert response completion
  task automatic pulse(input logic g);
    if (g)
      gc_reset = 1'b1;
    else
      alert_resp = 1'b1;
    @(posedge clk);
    #1;
    gc_reset = 1'b0;
    alert_resp = 1'b0;
    @(posedge clk);
    #1;
  endtask : pulse
endmodule : host_model

// ==== tb/test_temp_sensor_register_bank.sv ====
// Self-checking bench for the temperature sensor register bank
`timescale 1ns/1ps
module test_temp_sensor_register_bank;
  localparam int BASE = 20;
  localparam int LAT = 10;
  localparam logic [15:0] ID = 16'h3c96; // Arbitrary identifier value
  logic clk;
  logic arst_n;
  logic ce;
  temp_sensor_pkg::host_req_t host_req;
  temp_sensor_pkg::host_rsp_t host_rsp;
  logic gc_reset;
  logic alert_resp;
  logic conv_start;
  logic conv_done;
  logic [11:0] conv_val;
  logic alert_pin;
  logic alert_active;
  logic [15:0] v;
  logic [7:0] ptrs [5] = '{8'h01, 8'h02, 8'h03, 8'h0f, 8'h05};
  logic [15:0] vals [5] = '{16'h00ff, 16'h4b00, 16'h5000, ID, 16'h0000};
  int mismatches;
  int total_checks;
  int cyc;
  int ndone;
  int nstart;
  int last_launch;
  int gap;
  int k;
  int n0;

  temp_sensor_register_bank #(.DIE_ID_CODE(ID), .CONV_BASE_CYCLES(BASE)) u_temp_sensor_register_bank (
    .clk(clk), .arst_n(arst_n), .ce(ce), .host_req(host_req), .host_rsp(host_rsp),
    .gc_reset(gc_reset), .alert_resp(alert_resp), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_val), .alert_pin(alert_pin), .alert_active(alert_active));
  host_model u_host_model (.clk(clk), .host_rsp(host_rsp), .host_req(host_req),
    .gc_reset(gc_reset), .alert_resp(alert_resp));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Converter stand-in: fixed latency, one answer per launch
  initial
  begin
    conv_done = 1'b0;
    forever
    begin
      @(posedge clk);
      if (arst_n === 1'b1 && conv_start === 1'b1)
      begin
        repeat (LAT) @(posedge clk);
        #1;
        conv_done = 1'b1;
        @(posedge clk);
        #1;
        conv_done = 1'b0;
      end
    end
  end

  // Cycle count, launch spacing, completions and hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (conv_done === 1'b1)
      ndone++;
    if (conv_start === 1'b1 && arst_n === 1'b1)
    begin
      nstart++;
      gap = cyc - last_launch;
      last_launch = cyc;
    end
    if (cyc == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Returns just after the edge that took the next completion(s)
  task automatic wait_done(input int n);
    repeat (n)
    begin
      k = ndone;
      while (ndone == k)
      begin
        @(posedge clk);
        #1;
      end
    end
  endtask : wait_done

  // Four equal samples with fault depth four: only the last may flip the alert
  task automatic seq(input logic [11:0] t, input logic e_mid, input logic e_end);
    conv_val = t;
    for (int i = 1; i <= 4; i++)
    begin
      wait_done(1);
      chk({15'h0, alert_active}, {15'h0, ((i == 4) ? e_end : e_mid)});
    end
  endtask : seq

  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    ce = 1'b1;
    arst_n = 1'b0;
    conv_val = 12'hf9c;
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
    // Reset values, identifier and an unmapped pointer
    u_host_model.rd(8'h00, 2, v);
    chk(v, 16'h0000);
    foreach (ptrs[i])
    begin
      u_host_model.rd(ptrs[i], 2, v);
      chk(v, vals[i]);
    end
    // Result sits in 15:4 and ignores writes
    wait_done(1);
    u_host_model.rd(8'h00, 2, v);
    chk(v, 16'hf9c0);
    u_host_model.rd(8'h00, 1, v);
    chk(v, 16'h00f9);
    u_host_model.wr(8'h00, 16'h1234, 2);
    u_host_model.wr(8'h0f, 16'h1234, 2);
    u_host_model.rd(8'h00, 2, v);
    chk(v, 16'hf9c0);
    u_host_model.rd(8'h0f, 2, v);
    chk(v, ID);
    // Trigger reads zero; active-high polarity idles the pin low
    u_host_model.wr(8'h01, 16'h9c5a, 2);
    u_host_model.rd(8'h01, 2, v);
    chk(v, 16'h1c5a);
    chk({15'h0, alert_pin}, 16'h0000);
    u_host_model.wr(8'h01, 16'h1800, 1);
    u_host_model.rd(8'h01, 2, v);
    chk(v, 16'h185a);
    u_host_model.rd(8'h01, 1, v);
    chk(v, 16'h0018);
    chk({15'h0, alert_pin}, 16'h0001);
    u_host_model.wr(8'h02, 16'h0100, 2);
    u_host_model.wr(8'h03, 16'h0200, 2);
    u_host_model.rd(8'h02, 2, v);
    chk(v, 16'h0100);
    u_host_model.rd(8'h03, 2, v);
    chk(v, 16'h0200);
    // Comparator with hysteresis between the limits
    seq(12'h020, 1'b0, 1'b1);
    seq(12'h010, 1'b1, 1'b1);
    chk({15'h0, alert_pin}, 16'h0000);
    seq(12'h00f, 1'b1, 1'b0);
    seq(12'h020, 1'b0, 1'b1);
    // Mode write drops the alert; interrupt mode alternates limits
    conv_val = 12'h018;
    u_host_model.wr(8'h01, 16'h1a00, 2);
    chk({15'h0, alert_active}, 16'h0000);
    seq(12'h020, 1'b0, 1'b1);
    u_host_model.rd(8'h02, 1, v);
    chk({15'h0, alert_active}, 16'h0000);
    seq(12'h00f, 1'b0, 1'b1);
    u_host_model.pulse(1'b0);
    chk({15'h0, alert_active}, 16'h0000);
    // Shutdown halts launches; trigger gives exactly one conversion
    u_host_model.wr(8'h01, 16'h0100, 2);
    repeat (100) @(posedge clk);
    #1;
    n0 = nstart;
    repeat (100) @(posedge clk);
    #1;
    chk(16'(nstart - n0), 16'h0000);
    conv_val = 12'h7ff;
    u_host_model.wr(8'h01, 16'h8100, 2);
    wait_done(1);
    u_host_model.rd(8'h00, 2, v);
    chk(v, 16'h7ff0);
    repeat (100) @(posedge clk);
    #1;
    chk(16'(nstart - n0), 16'h0001);
    // Clock enable low freezes the bank, so this write is lost
    ce = 1'b0;
    u_host_model.wr(8'h01, 16'h0000, 2);
    ce = 1'b1;
    u_host_model.rd(8'h01, 2, v);
    chk(v, 16'h0100);
    chk(16'(nstart - n0), 16'h0001);
    // General call restores reset values
    u_host_model.pulse(1'b1);
    u_host_model.rd(8'h00, 2, v);
    chk(v, 16'h0000);
    u_host_model.rd(8'h01, 2, v);
    chk(v, 16'h00ff);
    // Launch spacing doubles per rate step
    for (int r = 0; r < 4; r++)
    begin
      u_host_model.wr(8'h01, {1'b0, 2'(r), 13'h0000}, 2);
      wait_done(3);
      chk(16'(gap), 16'(BASE << r));
      // Depth code zero: one hot sample above the upper limit alerts
      chk({15'h0, alert_active}, 16'h0001);
      chk({15'h0, alert_pin}, 16'h0000);
    end
    print_verdict();
  end
endmodule : test_temp_sensor_register_bank
